// file: sdrt_ctrl_model.sv
// Memory controller model that issues link commands with per-bank spacing.
`timescale 1ns/10ps
module sdrt_ctrl_model #(
    parameter int T_RAS = 8,
    parameter int T_RP  = 11,
    parameter int T_RC  = 19,
    parameter int WR_PREAMBLE_CK = 2,
    parameter int CWL_LOWEST     = 9
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                req,
    input  wire sdrt_pkg::sdrt_cmd_e req_code,
    input  wire logic [3:0]          req_bank,
    input  wire logic [7:0]          req_col,
    input  wire logic                req_bsel,
    input  wire logic                req_ap,
    input  wire logic                rude,
    input  wire logic [7:0]          rd_pre_gap,
    input  wire logic                int_precharge,
    input  wire logic [3:0]          int_precharge_bank,
    output sdrt_pkg::sdrt_cmd_e      cmd_code,
    output logic [3:0]               cmd_bank,
    output logic [7:0]               cmd_column,
    output logic                     burst_select_address_bit,
    output logic                     cmd_auto_precharge,
    output logic                     done
);
    import sdrt_pkg::*;
    int   since_rd[16];
    int   since_act[16];
    int   since_pre[16];
    logic ok;
    // Write latency the model would program; writes carry no data in this model.
    localparam int CWL_USED = (WR_PREAMBLE_CK == 2) ? CWL_LOWEST + 1 : CWL_LOWEST;

    // Each bank keeps its own timers, and a request waits until its bank allows it, except a precharge sent with rude set.
    always @(posedge clock) begin
        for (int b = 0; b < 16; b++) begin
            since_rd[b] = rst ? 1000 : since_rd[b] + 1;
            since_act[b] = rst ? 1000 : since_act[b] + 1;
            since_pre[b] = rst ? 1000 : since_pre[b] + 1;
        end
        if (int_precharge)
            since_pre[int_precharge_bank] = 0;
        case (req_code)
            CMD_PRE: ok = rude || (since_rd[req_bank] >= int'(rd_pre_gap)
                          && since_act[req_bank] >= T_RAS);
            CMD_ACT: ok = since_pre[req_bank] >= T_RP
                          && since_act[req_bank] >= T_RC;
            default: ok = 1'b1;
        endcase
        done <= 1'b0;
        cmd_code <= CMD_NOP;
        // Idle bank, column and burst select fields toggle so that nothing can lean on a stale value; auto precharge is cleared.
        cmd_bank <= rst ? 4'h0 : ~cmd_bank;
        cmd_column <= rst ? 8'h00 : ~cmd_column;
        burst_select_address_bit <= rst ? 1'b0 : ~burst_select_address_bit;
        cmd_auto_precharge <= 1'b0;
        if (req && !done && !rst && ok) begin
            cmd_code <= req_code;
            cmd_bank <= req_bank;
            cmd_column <= req_col;
            burst_select_address_bit <= req_bsel;
            cmd_auto_precharge <= req_ap;
            done <= 1'b1;
            if (req_code == CMD_RD)
                since_rd[req_bank] = 0;
            if (req_code == CMD_ACT)
                since_act[req_bank] = 0;
            if (req_code == CMD_PRE)
                since_pre[req_bank] = 0;
        end
    end
endmodule // sdrt_ctrl_model

// file: sdrt_pkg.sv
// Constants, command codes and register layout for the read-path timing block.
package sdrt_pkg;
    typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE} sdrt_cmd_e;

    localparam logic [3:0] ADDR_MODE   = 4'h0;
    localparam logic [3:0] ADDR_LAT    = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    localparam int MODE_BL_LSB   = 0;
    localparam int MODE_RTP_LSB  = 9;
    localparam int LAT_CL_LSB    = 0;
    localparam int LAT_AL_LSB    = 8;
    localparam int LAT_PL_LSB    = 12;
    localparam int LAT_PAR_BIT   = 16;
    localparam int LAT_DBI_BIT   = 17;

    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_SELECT = 2'h1;
    localparam logic [1:0] BL_CHOP4  = 2'h2;
    localparam logic [1:0] AL_OFF    = 2'h0;
    localparam logic [1:0] AL_CL_M1  = 2'h1;
    localparam logic [1:0] AL_CL_M2  = 2'h2;

    localparam logic [31:0] MODE_RESET = 32'h0000_0200;
    localparam logic [31:0] LAT_RESET  = 32'h0000_000b;

    localparam int RTP_CODE_BASE = 5;
    localparam int RTP_MIN_CK    = 4;
    localparam int RTP_MIN_PS    = 7500;
    localparam int CLK_PERIOD_PS = 100000;
    localparam int RTP_NS_CYC_RAW = (RTP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RTP_NS_CYC    = (RTP_NS_CYC_RAW < 1) ? 1 : RTP_NS_CYC_RAW;
    localparam int BEATS_FULL    = 8;
    localparam int BEATS_CHOP    = 4;
endpackage

// file: sdrt_read_path.sv
// Read-path timing of the memory device: latency, burst length, bus inversion, auto precharge.
`timescale 1ns/10ps
module sdrt_read_path #(
    parameter int NUM_BANKS  = 16,
    parameter int PIPE_DEPTH = 80
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    input  wire sdrt_pkg::sdrt_cmd_e   cmd_code,
    input  wire logic [3:0]            cmd_bank,
    input  wire logic [7:0]            cmd_column,
    input  wire logic                  burst_select_address_bit,
    input  wire logic                  cmd_auto_precharge,
    output logic [7:0]                 dq_out,
    output logic                       dq_oe_n,
    output logic                       read_valid,
    output logic                       bus_inversion_flag_n,
    output logic                       int_precharge,
    output logic [3:0]                 int_precharge_bank
);
    import sdrt_pkg::*;

    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // Register file and bus slave.
    logic [31:0] mode_register_zero_r, mode_nxt;
    logic [31:0] lat_r, lat_nxt;
    logic        viol_r, viol_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        wait_r, wait_nxt;
    logic        viol_set;
    logic        burst_busy;
    logic        pend_any;

    logic [1:0]  burst_mode;
    logic [2:0]  rtp_code;
    logic [4:0]  column_latency;
    logic [1:0]  al_mode;
    logic [2:0]  parity_latency;
    logic        par_en;
    logic        dbi_en;
    logic [6:0]  additive_latency;
    logic [6:0]  read_latency;
    logic [6:0]  rtp_eff;

    assign burst_mode     = mode_register_zero_r[MODE_BL_LSB +: 2];
    assign rtp_code       = mode_register_zero_r[MODE_RTP_LSB +: 3];
    assign column_latency = lat_r[LAT_CL_LSB +: 5];
    assign al_mode        = lat_r[LAT_AL_LSB +: 2];
    assign parity_latency = lat_r[LAT_PL_LSB +: 3];
    assign par_en         = lat_r[LAT_PAR_BIT];
    assign dbi_en         = lat_r[LAT_DBI_BIT];

    always_comb begin
        logic [6:0] enc;
        logic [6:0] rl;
        enc = 7'(RTP_CODE_BASE) + {4'h0, rtp_code};
        rl  = 7'h00;
        rtp_eff = enc;
        if (rtp_eff < 7'(RTP_MIN_CK)) begin
            rtp_eff = 7'(RTP_MIN_CK);
        end
        if (rtp_eff < 7'(RTP_NS_CYC)) begin
            rtp_eff = 7'(RTP_NS_CYC);
        end
        case (al_mode)
            AL_CL_M1: additive_latency = {2'h0, column_latency} - 7'h01;
            AL_CL_M2: additive_latency = {2'h0, column_latency} - 7'h02;
            default:  additive_latency = 7'h00;
        endcase
        rl = {2'h0, column_latency} + additive_latency
             + (par_en ? {4'h0, parity_latency} : 7'h00);
        read_latency = (rl < 7'h02) ? 7'h02 : rl;
    end

    always_comb begin
        logic acc;
        acc       = !wait_r;
        mode_nxt  = mode_register_zero_r;
        lat_nxt   = lat_r;
        rdata_nxt = rdata_r;
        wait_nxt  = 1'b1;
        if ((avs_read || avs_write) && wait_r) begin
            wait_nxt = 1'b0;
            case (avs_address)
                ADDR_MODE:   rdata_nxt = mode_register_zero_r;
                ADDR_LAT:    rdata_nxt = lat_r;
                ADDR_STATUS: rdata_nxt = {29'h0, pend_any, burst_busy, viol_r};
                default:     rdata_nxt = 32'h0;
            endcase
        end
        viol_nxt = viol_r;
        for (int b = 0; b < 4; b++) begin
            if (acc && avs_write && avs_byteenable[b]) begin
                if (avs_address == ADDR_MODE) begin
                    mode_nxt[8*b +: 8] = avs_writedata[8*b +: 8];
                end
                if (avs_address == ADDR_LAT) begin
                    lat_nxt[8*b +: 8] = avs_writedata[8*b +: 8];
                end
            end
        end
        if (acc && avs_write && avs_byteenable[0] && avs_address == ADDR_STATUS
            && avs_writedata[0]) begin
            viol_nxt = 1'b0;
        end
        if (viol_set) begin
            viol_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_register_zero_r <= MODE_RESET;
            lat_r                <= LAT_RESET;
            viol_r               <= 1'b0;
            rdata_r              <= 32'h0;
            wait_r               <= 1'b1;
        end else begin
            mode_register_zero_r <= mode_nxt;
            lat_r                <= lat_nxt;
            viol_r               <= viol_nxt;
            rdata_r              <= rdata_nxt;
            wait_r               <= wait_nxt;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;

    // Per-bank read-to-precharge timers; they drive auto precharge and flag early precharges.
    logic [7:0] rtp_cnt_r [NUM_BANKS];
    logic [7:0] rtp_cnt_nxt [NUM_BANKS];
    logic       ap_r [NUM_BANKS];
    logic       ap_nxt [NUM_BANKS];
    logic       ipre_r, ipre_nxt;
    logic [3:0] ipre_bank_r, ipre_bank_nxt;
    logic       rd_acc;
    logic       ins_bc4;

    assign rd_acc = (cmd_code == CMD_RD);

    always_comb begin
        logic fired;
        fired         = 1'b0;
        ipre_nxt      = 1'b0;
        ipre_bank_nxt = ipre_bank_r;
        viol_set      = (cmd_code == CMD_PRE) && (rtp_cnt_r[cmd_bank] > 8'h01);
        for (int b = 0; b < NUM_BANKS; b++) begin
            rtp_cnt_nxt[b] = (rtp_cnt_r[b] != 8'h00) ? rtp_cnt_r[b] - 8'h01 : 8'h00;
            ap_nxt[b] = ap_r[b];
            if (ap_r[b] && rtp_cnt_r[b] <= 8'h01 && !fired) begin
                fired         = 1'b1;
                ipre_nxt      = 1'b1;
                ipre_bank_nxt = 4'(b);
                ap_nxt[b]     = 1'b0;
            end
        end
        if (rd_acc) begin
            rtp_cnt_nxt[cmd_bank] = {1'b0, additive_latency} + {1'b0, rtp_eff};
            ap_nxt[cmd_bank]      = cmd_auto_precharge;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                rtp_cnt_r[b] <= 8'h00;
                ap_r[b]      <= 1'b0;
            end
            ipre_r      <= 1'b0;
            ipre_bank_r <= 4'h0;
        end else begin
            rtp_cnt_r   <= rtp_cnt_nxt;
            ap_r        <= ap_nxt;
            ipre_r      <= ipre_nxt;
            ipre_bank_r <= ipre_bank_nxt;
        end
    end

    assign int_precharge      = ipre_r;
    assign int_precharge_bank = ipre_bank_r;

    // Latency pipeline: a read enters at slot read_latency-2 and launches its burst at slot 0.
    // The beat register adds the last cycle, so the first beat stands read_latency cycles on.
    logic       pvld_r [PIPE_DEPTH];
    logic       pvld_nxt [PIPE_DEPTH];
    logic [7:0] pcol_r [PIPE_DEPTH];
    logic [7:0] pcol_nxt [PIPE_DEPTH];
    logic       pbc4_r [PIPE_DEPTH];
    logic       pbc4_nxt [PIPE_DEPTH];

    always_comb begin
        case (burst_mode)
            BL_SELECT: ins_bc4 = !burst_select_address_bit;
            BL_CHOP4:  ins_bc4 = 1'b1;
            default:   ins_bc4 = 1'b0;
        endcase
    end

    always_comb begin
        pend_any = 1'b0;
        for (int i = 0; i < PIPE_DEPTH; i++) begin
            pend_any    = pend_any | pvld_r[i];
            pvld_nxt[i] = (i < PIPE_DEPTH - 1) ? pvld_r[i+1] : 1'b0;
            pcol_nxt[i] = (i < PIPE_DEPTH - 1) ? pcol_r[i+1] : 8'h00;
            pbc4_nxt[i] = (i < PIPE_DEPTH - 1) ? pbc4_r[i+1] : 1'b0;
        end
        if (rd_acc) begin
            pvld_nxt[read_latency - 7'h02] = 1'b1;
            pcol_nxt[read_latency - 7'h02] = cmd_column;
            pbc4_nxt[read_latency - 7'h02] = ins_bc4;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                pvld_r[i] <= 1'b0;
                pcol_r[i] <= 8'h00;
                pbc4_r[i] <= 1'b0;
            end
        end else begin
            pvld_r <= pvld_nxt;
            pcol_r <= pcol_nxt;
            pbc4_r <= pbc4_nxt;
        end
    end

    // Burst engine; a later launch cuts a running burst short.
    logic [3:0] left_r, left_nxt;
    logic [7:0] bcol_r, bcol_nxt;
    logic [2:0] bidx_r, bidx_nxt;
    logic [7:0] dq_r, dq_nxt;
    logic       dv_r, dv_nxt;
    logic       dbi_n_r, dbi_n_nxt;
    logic       oe_n_r, oe_n_nxt;

    assign burst_busy = (left_r != 4'h0);

    always_comb begin
        logic [7:0] beat;
        beat      = 8'h00;
        left_nxt  = left_r;
        bcol_nxt  = bcol_r;
        bidx_nxt  = bidx_r;
        dv_nxt    = 1'b0;
        dq_nxt    = dq_r;
        dbi_n_nxt = 1'b1;
        oe_n_nxt  = 1'b1;
        if (pvld_r[0]) begin
            bcol_nxt = pcol_r[0];
            bidx_nxt = 3'h0;
            left_nxt = pbc4_r[0] ? 4'(BEATS_CHOP) : 4'(BEATS_FULL);
        end
        beat = bcol_nxt + {5'h0, bidx_nxt};
        if (left_nxt != 4'h0) begin
            dv_nxt   = 1'b1;
            oe_n_nxt = 1'b0;
            dq_nxt   = beat;
            left_nxt = left_nxt - 4'h1;
            bidx_nxt = bidx_nxt + 3'h1;
            if (dbi_en && ones8(beat) > 4'h4) begin
                dq_nxt    = ~beat;
                dbi_n_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            left_r  <= 4'h0;
            bcol_r  <= 8'h00;
            bidx_r  <= 3'h0;
            dq_r    <= 8'h00;
            dv_r    <= 1'b0;
            dbi_n_r <= 1'b1;
            oe_n_r  <= 1'b1;
        end else begin
            left_r  <= left_nxt;
            bcol_r  <= bcol_nxt;
            bidx_r  <= bidx_nxt;
            dq_r    <= dq_nxt;
            dv_r    <= dv_nxt;
            dbi_n_r <= dbi_n_nxt;
            oe_n_r  <= oe_n_nxt;
        end
    end

    assign dq_out               = dq_r;
    assign read_valid           = dv_r;
    assign dq_oe_n              = oe_n_r;
    assign bus_inversion_flag_n = dbi_n_r;

    // Latency measurement for a read issued with nothing in flight.
    logic       meas_on_r, meas_on_nxt;
    logic [6:0] meas_cnt_r, meas_cnt_nxt;
    logic [6:0] meas_rl_r, meas_rl_nxt;
    always_comb begin
        meas_on_nxt  = meas_on_r;
        meas_cnt_nxt = meas_cnt_r;
        meas_rl_nxt  = meas_rl_r;
        if (rd_acc && !pend_any && !burst_busy && !meas_on_r) begin
            meas_on_nxt  = 1'b1;
            meas_cnt_nxt = 7'h01;
            meas_rl_nxt  = read_latency;
        end else if (meas_on_r) begin
            meas_on_nxt  = !dv_r && !rd_acc;
            meas_cnt_nxt = meas_cnt_r + 7'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            meas_on_r  <= 1'b0;
            meas_cnt_r <= 7'h00;
            meas_rl_r  <= 7'h00;
        end else begin
            meas_on_r  <= meas_on_nxt;
            meas_cnt_r <= meas_cnt_nxt;
            meas_rl_r  <= meas_rl_nxt;
        end
    end

    chk_read_latency_value: assert property (@(posedge clock) disable iff (rst)
        (meas_on_r && $rose(dv_r)) |-> (meas_cnt_r == meas_rl_r))
        else $error("read data launched at the wrong latency");
    chk_rtp_floor: assert property (@(posedge clock) disable iff (rst)
        rtp_eff >= 7'(RTP_MIN_CK) && rtp_eff >= 7'(RTP_NS_CYC))
        else $error("read to precharge delay below its floor");
    chk_rtp_code_six: assert property (@(posedge clock) disable iff (rst)
        (rtp_code == 3'h1) |-> (rtp_eff == 7'd6))
        else $error("delay code 001 does not give six clocks");
    chk_fixed_eight: assert property (@(posedge clock) disable iff (rst)
        (rd_acc && burst_mode == BL_FIXED8) |=> pbc4_r[read_latency - 7'h02] == 1'b0)
        else $error("fixed burst mode did not queue eight beats");
    chk_select_bit: assert property (@(posedge clock) disable iff (rst)
        (rd_acc && burst_mode == BL_SELECT) |-> ins_bc4 == !burst_select_address_bit)
        else $error("per command burst choice ignores the select bit");
    chk_fixed_chop: assert property (@(posedge clock) disable iff (rst)
        (pvld_r[0] && pbc4_r[0]) |=> read_valid [*4] ##1 (!read_valid || $past(pvld_r[0])))
        else $error("four beat chop has the wrong length");
    chk_eight_beats: assert property (@(posedge clock) disable iff (rst)
        (pvld_r[0] && !pbc4_r[0] && !pvld_r[1] && !pvld_r[2] && !pvld_r[3]
         && !pvld_r[4] && !pvld_r[5] && !pvld_r[6]) |=> read_valid [*8])
        else $error("eight beat burst cut short");
    chk_al_minus_two: assert property (@(posedge clock) disable iff (rst)
        (al_mode == AL_CL_M2) |-> (read_latency == 7'(2 * column_latency) - 7'h02
                                   + (par_en ? {4'h0, parity_latency} : 7'h00)))
        else $error("additive latency of column latency minus two misapplied");
    chk_dbi_flag: assert property (@(posedge clock) disable iff (rst)
        read_valid |-> (dbi_en ? ones8(dq_out) <= 4'h4 : bus_inversion_flag_n))
        else $error("inversion flag does not match the beat");
endmodule // sdrt_read_path

// file: tb.sv
// Self-checking bench for the read-path timing block with a controller model.
`timescale 1ns/10ps
module tb;
    import sdrt_pkg::*;
    typedef struct {int due; logic [7:0] d;} sdrt_beat_s;
    logic        clock = 1'b0, rst = 1'b1, req = 1'b0, req_bsel = 1'b0, req_ap = 1'b0;
    logic        avs_read = 1'b0, avs_write = 1'b0, rude = 1'b0, avs_waitrequest;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf, req_bank = 4'h0;
    logic [3:0]  cmd_bank, int_precharge_bank, ap_bank;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [31:0] mode_sh = MODE_RESET, lat_sh = LAT_RESET, seed = 32'h0000_5638;
    sdrt_cmd_e   cmd_code, req_code = CMD_NOP;
    logic [7:0]  cmd_column, req_col = 8'h00, dq_out, rd_pre_gap;
    logic        burst_select_address_bit, cmd_auto_precharge, done;
    logic        dq_oe_n, read_valid, bus_inversion_flag_n, int_precharge;
    int          err_count = 0, n_compared = 0, cyc = 0, apq[$];
    sdrt_beat_s  bq[$];

    always #50 clock = ~clock;

    sdrt_read_path uut (
        .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmd_code(cmd_code),
        .cmd_bank(cmd_bank), .cmd_column(cmd_column),
        .burst_select_address_bit(burst_select_address_bit),
        .cmd_auto_precharge(cmd_auto_precharge), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .read_valid(read_valid), .bus_inversion_flag_n(bus_inversion_flag_n),
        .int_precharge(int_precharge), .int_precharge_bank(int_precharge_bank));
    sdrt_ctrl_model ctrl (
        .clock(clock), .rst(rst), .req(req), .req_code(req_code), .req_bank(req_bank),
        .req_col(req_col), .req_bsel(req_bsel), .req_ap(req_ap), .rude(rude),
        .rd_pre_gap(rd_pre_gap), .int_precharge(int_precharge),
        .int_precharge_bank(int_precharge_bank), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
        .cmd_column(cmd_column), .burst_select_address_bit(burst_select_address_bit),
        .cmd_auto_precharge(cmd_auto_precharge), .done(done));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int al_f();
        int cl = int'(lat_sh[4:0]);
        return lat_sh[9:8] == AL_CL_M1 ? cl - 1 : lat_sh[9:8] == AL_CL_M2 ? cl - 2 : 0;
    endfunction
    function automatic int read_to_precharge_delay_f();
        int t = RTP_CODE_BASE + int'(mode_sh[11:9]);
        t = t < RTP_MIN_CK ? RTP_MIN_CK : t;
        return t < RTP_NS_CYC ? RTP_NS_CYC : t;
    endfunction
    task automatic fail(input string m);
        err_count++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int i = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        if (i >= 50) begin
            fail("bus timeout");
            summarize();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        if (a == ADDR_MODE)
            mode_sh = d;
        if (a == ADDR_LAT)
            lat_sh = d;
        rd_pre_gap <= 8'(al_f() + read_to_precharge_delay_f());
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        n_compared++;
        if ((q & m) !== e)
            fail("register read");
    endtask
    task automatic cmd(input sdrt_cmd_e c, input logic [3:0] b, input logic ap, input logic r);
        logic [31:0] x = rnd();
        int i = 0;
        req <= 1'b1;
        req_code <= c;
        req_bank <= b;
        req_col <= x[7:0];
        req_bsel <= x[8];
        req_ap <= ap;
        rude <= r;
        do begin
            @(posedge clock);
            i++;
        end while (done !== 1'b1 && i < 200);
        if (i >= 200) begin
            fail("command timeout");
            summarize();
        end
        req <= 1'b0;
        @(posedge clock);
    endtask
    task automatic drain();
        int i;
        for (i = 0; i < 100 && (bq.size() > 0 || apq.size() > 0); i++)
            @(posedge clock);
        if (i >= 100) begin
            fail("drain timeout");
            summarize();
        end
        repeat (2) @(posedge clock);
    endtask
    task automatic reads(input logic [3:0] b, input logic ap);
        // Only the last read may close the bank; later reads would need a new activate.
        for (int n = 0; n < 4; n++) begin
            cmd(CMD_RD, b, ap && n == 3, 1'b0);
            repeat (6) @(posedge clock);
        end
        drain();
    endtask

    // Reference model: each read seen on the link queues its expected beats, and its precharge if it carries auto precharge.
    always @(posedge clock) begin
        int rl, n;
        logic ev, ea, inv;
        logic [7:0] e;
        cyc++;
        if (!rst) begin
            if (cmd_code == CMD_RD) begin
                rl = int'(lat_sh[4:0]) + al_f();
                rl += lat_sh[LAT_PAR_BIT] ? int'(lat_sh[14:12]) : 0;
                rl = rl < 2 ? 2 : rl;
                n = mode_sh[1:0] == BL_CHOP4 ? 4 : 8;
                n = mode_sh[1:0] == BL_SELECT && !burst_select_address_bit ? 4 : n;
                for (int i = 0; i < n; i++)
                    bq.push_back('{cyc + rl + i, 8'(cmd_column + 8'(i))});
                if (cmd_auto_precharge) begin
                    apq.push_back(cyc + al_f() + read_to_precharge_delay_f() + 1);
                    ap_bank = cmd_bank;
                end
            end
            ev = bq.size() > 0 && bq[0].due == cyc;
            ea = apq.size() > 0 && apq[0] == cyc;
            e = ev ? bq[0].d : 8'h00;
            inv = ev && lat_sh[LAT_DBI_BIT] && $countones(e) > 4;
            n_compared++;
            if (read_valid !== ev || dq_oe_n !== !ev)
                fail("beat timing");
            if (bus_inversion_flag_n !== !inv || (ev && dq_out !== (inv ? ~e : e)))
                fail("beat data");
            if (int_precharge !== ea || (ea && int_precharge_bank !== ap_bank))
                fail("auto precharge");
            if (ev)
                void'(bq.pop_front());
            if (ea)
                void'(apq.pop_front());
        end
    end

    initial begin
        logic [31:0] lat_tab[5];
        lat_tab = '{32'h0001_400b, 32'h0001_420b, 32'h0000_410b, 32'h0000_0202, 32'h0002_000b};
        rd_pre_gap <= 8'(al_f() + read_to_precharge_delay_f());
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rchk(ADDR_MODE, MODE_RESET, 32'hffff_ffff);
        rchk(ADDR_LAT, LAT_RESET, 32'hffff_ffff);
        wreg(4'hc, 32'hffff_ffff);
        rchk(4'hc, 32'h0, 32'hffff_ffff);
        $display("test registers finished");
        for (int k = 0; k < 4; k++) begin
            wreg(ADDR_MODE, 32'h0000_0200 | 32'(k));
            reads(4'(k), 1'b0);
        end
        $display("test burst length finished");
        wreg(ADDR_MODE, MODE_RESET);
        foreach (lat_tab[k]) begin
            wreg(ADDR_LAT, lat_tab[k]);
            reads(4'(k), 1'b0);
        end
        $display("test latency finished");
        wreg(ADDR_LAT, 32'h0000_020b);
        for (int k = 0; k < 8; k++) begin
            wreg(ADDR_MODE, 32'(k) << MODE_RTP_LSB);
            reads(4'(k + 8), 1'b1);
        end
        $display("test auto precharge finished");
        wreg(ADDR_LAT, LAT_RESET);
        wreg(ADDR_MODE, MODE_RESET);
        cmd(CMD_ACT, 4'h3, 1'b0, 1'b0);
        cmd(CMD_RD, 4'h3, 1'b0, 1'b0);
        cmd(CMD_PRE, 4'h3, 1'b0, 1'b0);
        cmd(CMD_ACT, 4'h3, 1'b0, 1'b0);
        cmd(CMD_WR, 4'h3, 1'b0, 1'b0);
        drain();
        rchk(ADDR_STATUS, 32'h0, 32'h1);
        cmd(CMD_RD, 4'h3, 1'b0, 1'b0);
        cmd(CMD_PRE, 4'h3, 1'b0, 1'b1);
        drain();
        rchk(ADDR_STATUS, 32'h1, 32'h1);
        wreg(ADDR_STATUS, 32'h1);
        rchk(ADDR_STATUS, 32'h0, 32'h1);
        $display("test bank spacing finished");
        summarize();
    end
endmodule // tb
